// File: verilog/tla_pkg.sv
// Overview of operation
// - Shared pin is event output when select zero
// - Mask bit set keeps event output released
// - Compare readings to limits at conversion end
// - Any flag except busy/open pulls output low
// - Comparator mode releases once condition clears
// - Comparator bit selects mode; resets to interrupt
// - Interrupt mode status read sets mask bit
// - Flags except busy clear on read, reset next conversion
// - Interrupt mode status read releases output
// - Alerting device acks and sends own address
// - Watch data line for arbitration loss
// - Full address sent: release output, set mask
// - Alert response only with alert-config bit low
// - Mask and alert-config bits zero after reset
// - Slave only: clock input, no stretching
// - Fixed slave address 1001100
// - Temperatures read-only, limits read-write
// - Remote temperature 11-bit left-justified in 16
// - Open flag alone never asserts output
`default_nettype none
package tla_pkg;
   localparam logic [6:0] OWN_ADDR = 7'h4C;
   localparam logic [6:0] ARA_ADDR = 7'h0C;
   localparam int ST_BUSY = 7;
   localparam int ST_LHIGH = 6;
   localparam int ST_RHIGH = 4;
   localparam int ST_RLOW = 3;
   localparam int ST_OPEN = 2;
   localparam int ST_RCRIT = 1;
   localparam logic [7:0] ALERT_SRC = 8'h5A;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam int REM_HI = 15;
   localparam int REM_LO = 5;
   localparam int REM_BYTE_LO = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] SYNC_RST = 2'h3;
   localparam int SYNC_W = 2;
   localparam int SCL_IDX = 1;
   localparam int SDA_IDX = 0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h3,
      ST_TX = 3'h2,
      ST_MACK = 3'h6,
      ST_RX = 3'h7
   } tla_state_t;
endpackage
`default_nettype wire

// File: verilog/tla_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tla_sync
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [tla_pkg::SYNC_W-1:0] async_in,
   output logic [tla_pkg::SYNC_W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < tla_pkg::SYNC_W; i++)
      begin : g_bit
         logic stage1_reg;
         logic stage2_reg;
         always_ff @(posedge sys_clk)
         begin
            if (!rst_n)
            begin
               stage1_reg <= tla_pkg::SYNC_RST[i];
               stage2_reg <= tla_pkg::SYNC_RST[i];
            end
            else
            begin
               stage1_reg <= async_in[i];
               stage2_reg <= stage1_reg;
            end
         end
         assign sync_out[i] = stage2_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// File: verilog/tla_alert.sv
`timescale 1ns/1ns
`default_nettype none
module tla_alert
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic conv_done,
   input wire logic [7:0] local_temp,
   input wire logic [15:0] remote_temp,
   input wire logic [7:0] local_high_limit,
   input wire logic [15:0] remote_high_limit,
   input wire logic [15:0] remote_low_limit,
   input wire logic [7:0] critical_limit,
   input wire logic busy_in,
   input wire logic diode_open_in,
   input wire logic pin_function_select,
   input wire logic comparator_mode,
   input wire logic alert_config,
   input wire logic mask_wr,
   input wire logic mask_wdata,
   input wire logic status_rd,
   output logic event_mask_bit,
   output logic [7:0] status_flags,
   output logic alert_o,
   output logic alert_oe_n,
   input wire logic smb_clk,
   input wire logic smb_dat_i,
   output logic smb_dat_o,
   output logic smb_dat_oe_n
);
   logic [1:0] pins_sync;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   tla_pkg::tla_state_t state_reg;
   tla_pkg::tla_state_t state_next;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic phase_reg;
   logic phase_next;
   logic rw_reg;
   logic rw_next;
   logic ara_reg;
   logic ara_next;
   logic dat_oe_n_reg;
   logic dat_oe_n_next;
   logic ara_done;
   logic smb_status_rd;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic mask_reg;
   logic mask_next;
   logic cmp_hit_reg;
   logic cmp_hit_next;
   logic alert_oe_n_reg;
   logic alert_oe_n_next;
   logic lhigh_hit;
   logic rhigh_hit;
   logic rlow_hit;
   logic rcrit_hit;
   logic any_hit;
   logic flagged;
   logic asserting;
   logic rd_any;

   tla_sync u_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({smb_clk, smb_dat_i}),
      .sync_out(pins_sync)
   );

   assign scl = pins_sync[tla_pkg::SCL_IDX];
   assign sda = pins_sync[tla_pkg::SDA_IDX];
   assign scl_rise = scl && !scl_prev_reg;
   assign scl_fall = !scl && scl_prev_reg;
   assign start_det = scl && scl_prev_reg && sda_prev_reg && !sda;
   assign stop_det = scl && scl_prev_reg && !sda_prev_reg && sda;

   // Limit comparisons on signed readings; remote high/low use the 11 justified bits, critical uses the upper 8
   // Readings are inputs only; nothing here can write them
   assign lhigh_hit = $signed(local_temp) > $signed(local_high_limit);
   assign rhigh_hit = $signed(remote_temp[tla_pkg::REM_HI:tla_pkg::REM_LO])
      > $signed(remote_high_limit[tla_pkg::REM_HI:tla_pkg::REM_LO]);
   assign rlow_hit = $signed(remote_temp[tla_pkg::REM_HI:tla_pkg::REM_LO])
      < $signed(remote_low_limit[tla_pkg::REM_HI:tla_pkg::REM_LO]);
   assign rcrit_hit = $signed(remote_temp[tla_pkg::REM_HI:tla_pkg::REM_BYTE_LO])
      > $signed(critical_limit);
   assign any_hit = lhigh_hit || rhigh_hit || rlow_hit || rcrit_hit;
   assign flagged = |(status_reg & tla_pkg::ALERT_SRC);
   assign asserting = comparator_mode ? cmp_hit_reg : flagged;
   assign rd_any = status_rd || smb_status_rd;

   // Serial slave: address match, alert response, status byte reads
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      phase_next = phase_reg;
      rw_next = rw_reg;
      ara_next = ara_reg;
      ara_done = 1'b0;
      smb_status_rd = 1'b0;
      if (start_det)
      begin
         state_next = tla_pkg::ST_ADDR;
         cnt_next = 3'h0;
         ara_next = 1'b0;
      end
      else if (stop_det)
         state_next = tla_pkg::ST_IDLE;
      else
      begin
         unique case (state_reg)
            tla_pkg::ST_IDLE:
               state_next = tla_pkg::ST_IDLE;
            tla_pkg::ST_ADDR, tla_pkg::ST_RX:
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda};
                  cnt_next = cnt_reg + 3'h1;
                  phase_next = 1'b0;
                  if (cnt_reg == tla_pkg::BIT_LAST)
                  begin
                     state_next = tla_pkg::ST_ACK;
                     if (state_reg == tla_pkg::ST_ADDR)
                     begin
                        rw_next = sda;
                        if (shift_reg[6:0] == tla_pkg::OWN_ADDR)
                           ara_next = 1'b0;
                        else if (shift_reg[6:0] == tla_pkg::ARA_ADDR && sda && asserting
                           && !mask_reg && !alert_config)
                           ara_next = 1'b1;
                        else
                           state_next = tla_pkg::ST_IDLE;
                     end
                  end
               end
            tla_pkg::ST_ACK:
               if (scl_fall)
               begin
                  phase_next = 1'b1;
                  if (phase_reg)
                  begin
                     cnt_next = 3'h0;
                     state_next = rw_reg ? tla_pkg::ST_TX : tla_pkg::ST_RX;
                     if (rw_reg)
                     begin
                        shift_next = ara_reg ? {tla_pkg::OWN_ADDR, 1'b0} : status_reg;
                        smb_status_rd = !ara_reg;
                     end
                  end
               end
            tla_pkg::ST_TX:
               if (scl_rise && shift_reg[7] && !sda)
                  state_next = tla_pkg::ST_IDLE;
               else if (scl_rise && ara_reg && cnt_reg == tla_pkg::BIT_LAST)
                  ara_done = 1'b1;
               else if (scl_fall)
               begin
                  shift_next = {shift_reg[6:0], 1'b1};
                  cnt_next = cnt_reg + 3'h1;
                  phase_next = 1'b0;
                  if (cnt_reg == tla_pkg::BIT_LAST)
                     state_next = tla_pkg::ST_MACK;
               end
            tla_pkg::ST_MACK:
               if (scl_rise)
                  phase_next = !sda;
               else if (scl_fall)
               begin
                  if (phase_reg && !ara_reg)
                  begin
                     state_next = tla_pkg::ST_TX;
                     shift_next = status_reg;
                     smb_status_rd = 1'b1;
                  end
                  else
                     state_next = tla_pkg::ST_IDLE;
               end
            default:
               state_next = tla_pkg::ST_IDLE;
         endcase
      end
      // Only the data line is ever driven, and only low; the clock is never held
      dat_oe_n_next = !((state_next == tla_pkg::ST_ACK && phase_next)
         || (state_next == tla_pkg::ST_TX && !shift_next[7]));
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         state_reg <= tla_pkg::ST_IDLE;
         cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         phase_reg <= 1'b0;
         rw_reg <= 1'b0;
         ara_reg <= 1'b0;
         dat_oe_n_reg <= 1'b1;
      end
      else
      begin
         scl_prev_reg <= scl;
         sda_prev_reg <= sda;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         phase_reg <= phase_next;
         rw_reg <= rw_next;
         ara_reg <= ara_next;
         dat_oe_n_reg <= dat_oe_n_next;
      end
   end

   // Status flags, mask bit, comparator result and event pin
   always_comb
   begin
      status_next = status_reg;
      if (rd_any)
         status_next = status_clr(status_reg);
      if (conv_done)
      begin
         status_next[tla_pkg::ST_LHIGH] = status_next[tla_pkg::ST_LHIGH] | lhigh_hit;
         status_next[tla_pkg::ST_RHIGH] = status_next[tla_pkg::ST_RHIGH] | rhigh_hit;
         status_next[tla_pkg::ST_RLOW] = status_next[tla_pkg::ST_RLOW] | rlow_hit;
         status_next[tla_pkg::ST_RCRIT] = status_next[tla_pkg::ST_RCRIT] | rcrit_hit;
         status_next[tla_pkg::ST_OPEN] = status_next[tla_pkg::ST_OPEN] | diode_open_in;
      end
      status_next[tla_pkg::ST_BUSY] = busy_in;
      mask_next = mask_reg;
      if (mask_wr)
         mask_next = mask_wdata;
      if ((rd_any && !comparator_mode && flagged) || ara_done)
         mask_next = 1'b1;
      cmp_hit_next = conv_done ? any_hit : cmp_hit_reg;
      alert_oe_n_next = !(!pin_function_select && !mask_next && asserting
         && !(rd_any && !comparator_mode));
   end

   function automatic logic [7:0] status_clr(input logic [7:0] s);
      status_clr = s & (8'h01 << tla_pkg::ST_BUSY);
   endfunction

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         status_reg <= tla_pkg::STATUS_RST;
         mask_reg <= 1'b0;
         cmp_hit_reg <= 1'b0;
         alert_oe_n_reg <= 1'b1;
      end
      else
      begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         cmp_hit_reg <= cmp_hit_next;
         alert_oe_n_reg <= alert_oe_n_next;
      end
   end

   assign event_mask_bit = mask_reg;
   assign status_flags = status_reg;
   assign alert_o = 1'b0;
   assign alert_oe_n = alert_oe_n_reg;
   assign smb_dat_o = 1'b0;
   assign smb_dat_oe_n = dat_oe_n_reg;

   mask_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (mask_reg || $past(pin_function_select)) |-> alert_oe_n)
      else $error("event pin driven while masked or deselected");
   flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (status_rd && !conv_done) |=> (status_reg & tla_pkg::ALERT_SRC) == 8'h00)
      else $error("flags survived a status read");
   flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (conv_done && rcrit_hit) |=> status_reg[tla_pkg::ST_RCRIT])
      else $error("critical flag not set after conversion");
   irq_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (status_rd && !comparator_mode && flagged) |=> mask_reg)
      else $error("status read did not set mask");
   open_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!comparator_mode && !flagged) |=> alert_oe_n)
      else $error("event pin driven with no limit flag");
   ara_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ara_done |=> (mask_reg && alert_oe_n))
      else $error("alert response did not release the pin");
   idle_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == tla_pkg::ST_IDLE && !start_det) |=> smb_dat_oe_n)
      else $error("data line driven while idle");
   cmp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !conv_done |=> $stable(cmp_hit_reg))
      else $error("comparator result changed between conversions");
endmodule
`default_nettype wire

// File: verilog/unused_placeholder_never.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: dv/tla_host.sv
`timescale 1ns/1ns
`default_nettype none
module tla_host
(
   output logic smb_clk,
   output logic sda_low,
   input wire logic sda_line
);
   initial
   begin
      smb_clk = 1'h1;
      sda_low = 1'h0;
   end

   // One 125 ns clock; data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      sda_low = !b;
      #31;
      smb_clk = 1'h1;
      #31;
      s = sda_line;
      #32;
      smb_clk = 1'h0;
      #31;
   endtask

   // Start, address with read bit, one byte read, nack, stop
   task automatic frame(input logic [7:0] addr, input logic [7:0] drive,
                        output logic [7:0] rx, output logic acked);
      logic s;
      sda_low = 1'h1;
      #62;
      smb_clk = 1'h0;
      #31;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(addr[i], s);
      end
      bit_io(1'h1, s);
      acked = !s;
      // A rival alerter is modelled by driving its address bits here
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(drive[i], s);
         rx[i] = s;
      end
      bit_io(1'h1, s);
      sda_low = 1'h1;
      #31;
      smb_clk = 1'h1;
      #31;
      sda_low = 1'h0;
      #62;
   endtask
endmodule
`default_nettype wire

// File: dv/temp_limit_alert_logic_test.sv
`timescale 1ns/1ns
`default_nettype none
module temp_limit_alert_logic_test;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic conv_done = 1'h0;
   logic mask_wr = 1'h0;
   logic mask_wdata = 1'h0;
   logic status_rd = 1'h0;
   logic busy_in = 1'h0;
   logic diode_open_in = 1'h0;
   logic pin_function_select = 1'h0;
   logic comparator_mode = 1'h0;
   logic alert_config = 1'h0;
   logic [7:0] local_temp = 8'h00;
   logic [7:0] local_high_limit = 8'h7F;
   logic [7:0] critical_limit = 8'h7F;
   logic [15:0] remote_temp = 16'h0000;
   logic [15:0] remote_high_limit = 16'h7FE0;
   logic [15:0] remote_low_limit = 16'h8000;
   logic event_mask_bit;
   logic [7:0] status_flags;
   logic alert_oe_n;
   logic smb_dat_oe_n;
   logic smb_clk;
   logic host_low;
   wire smb_dat_i;
   logic [31:0] rng = 32'h0000BF17;
   logic [31:0] r;
   logic [7:0] rx;
   logic [7:0] ef;
   logic ack;
   logic em;
   logic eph;
   int n_fail = 0;
   int tests_run = 0;

   // Wired-AND data line with pull-up
   assign smb_dat_i = !host_low && smb_dat_oe_n;
   always #5 sys_clk = !sys_clk;

   tla_alert u_dut (.sys_clk, .rst_n, .conv_done, .local_temp, .remote_temp,
      .local_high_limit, .remote_high_limit, .remote_low_limit, .critical_limit,
      .busy_in, .diode_open_in, .pin_function_select, .comparator_mode, .alert_config,
      .mask_wr, .mask_wdata, .status_rd, .event_mask_bit, .status_flags, .alert_o(),
      .alert_oe_n, .smb_clk, .smb_dat_i, .smb_dat_o(), .smb_dat_oe_n);

   tla_host u_host (.smb_clk(smb_clk), .sda_low(host_low), .sda_line(smb_dat_i));

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic [7:0] exp_flags();
      exp_flags = 8'h00;
      exp_flags[6] = $signed(local_temp) > $signed(local_high_limit);
      exp_flags[4] = $signed(remote_temp[15:5]) > $signed(remote_high_limit[15:5]);
      exp_flags[3] = $signed(remote_temp[15:5]) < $signed(remote_low_limit[15:5]);
      exp_flags[2] = diode_open_in;
      exp_flags[1] = $signed(remote_temp[15:8]) > $signed(critical_limit);
   endfunction

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask

   task automatic pulse(ref logic s);
      @(negedge sys_clk);
      s = 1'h1;
      @(negedge sys_clk);
      s = 1'h0;
      @(negedge sys_clk);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(negedge sys_clk);
      rst_n = 1'h1;
      repeat (4) @(negedge sys_clk);
      chk1("mask", 1'h0, event_mask_bit);
      chk8("status", 8'h00, status_flags);
      chk1("pin", 1'h1, alert_oe_n);
      chk1("data", 1'h1, smb_dat_oe_n);
      for (int i = 0; i < 40; i++)
      begin
         r = rnd();
         mask_wdata = r[0] & r[1];
         pulse(mask_wr);
         em = mask_wdata;
         pin_function_select = r[2] & r[3];
         comparator_mode = r[4];
         busy_in = r[5];
         diode_open_in = r[6];
         local_temp = r[15:8];
         local_high_limit = r[23:16];
         critical_limit = r[31:24];
         r = rnd();
         remote_temp = r[15:0];
         remote_high_limit = r[31:16];
         r = rnd();
         remote_low_limit = r[15:0];
         pulse(conv_done);
         ef = exp_flags();
         eph = !(!pin_function_select && !em && |(ef & tla_pkg::ALERT_SRC));
         chk8("status", {busy_in, ef[6:0]}, status_flags);
         chk1("mask", em, event_mask_bit);
         chk1("pin", eph, alert_oe_n);
         pulse(status_rd);
         em = em | (!comparator_mode && |(ef & tla_pkg::ALERT_SRC));
         chk8("cleared", {busy_in, 7'h00}, status_flags);
         chk1("mask", em, event_mask_bit);
         chk1("pin", comparator_mode ? eph : 1'h1, alert_oe_n);
      end
      comparator_mode = 1'h0;
      pin_function_select = 1'h0;
      diode_open_in = 1'h0;
      busy_in = 1'h0;
      mask_wdata = 1'h0;
      pulse(mask_wr);
      local_temp = 8'h7F;
      local_high_limit = 8'h00;
      remote_temp = 16'h0000;
      remote_high_limit = 16'h7FE0;
      remote_low_limit = 16'h8000;
      critical_limit = 8'h7F;
      pulse(conv_done);
      chk1("pin", 1'h0, alert_oe_n);
      alert_config = 1'h1;
      u_host.frame({tla_pkg::ARA_ADDR, 1'h1}, 8'hFF, rx, ack);
      chk1("ack", 1'h0, ack);
      alert_config = 1'h0;
      // Rival sends 1001010: matches for the first four bits, then wins at the fifth
      u_host.frame({tla_pkg::ARA_ADDR, 1'h1}, 8'h94, rx, ack);
      chk1("ack", 1'h1, ack);
      chk8("ara", 8'h94, rx);
      chk1("mask", 1'h0, event_mask_bit);
      chk1("pin", 1'h0, alert_oe_n);
      u_host.frame({tla_pkg::ARA_ADDR, 1'h1}, 8'hFF, rx, ack);
      chk1("ack", 1'h1, ack);
      chk8("ara", 8'h98, rx);
      chk1("mask", 1'h1, event_mask_bit);
      chk1("pin", 1'h1, alert_oe_n);
      u_host.frame({7'h4C, 1'h1}, 8'hFF, rx, ack);
      chk1("ack", 1'h1, ack);
      chk8("read", 8'h40, rx);
      chk8("cleared", 8'h00, status_flags);
      u_host.frame({7'h4D, 1'h1}, 8'hFF, rx, ack);
      chk1("ack", 1'h0, ack);
      wrap_up();
   end

   // About twelve times the expected run length
   initial
   begin
      #200000;
      n_fail++;
      wrap_up();
   end
endmodule
`default_nettype wire
